// file: logic/fsirq_pkg.sv
`default_nettype none
package fsirq_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] OFS_CTRL_LOW = 8'h0b;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h1e;
  // low control register fields
  localparam int LOW_GIE = 0;
  localparam int LOW_EXT_EN = 1;
  localparam int LOW_T0_EN = 2;
  localparam int LOW_T1_EN = 3;
  localparam int LOW_EXT_FLAG = 4;
  localparam int LOW_T0_FLAG = 5;
  localparam int LOW_T1_FLAG = 6;
  // high control register fields
  localparam int HIGH_T2_EN = 0;
  localparam int HIGH_T3_EN = 1;
  localparam int HIGH_T2_FLAG = 4;
  localparam int HIGH_T3_FLAG = 5;
  // writable masks; other bits read as zero
  localparam logic [7:0] LOW_MASK = 8'h7f;
  localparam logic [7:0] HIGH_MASK = 8'h33;
  // reset values
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  // number of sources and vectors, priority order
  localparam int NSRC = 5;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_T0 = 8'h08;
  localparam logic [7:0] VEC_T1 = 8'h0c;
  localparam logic [7:0] VEC_T2 = 8'h10;
  localparam logic [7:0] VEC_T3 = 8'h14;
  // register bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fsirq_bus_type;
  // acknowledge bundle toward the sequencer
  typedef struct packed {
    logic call;
    logic [7:0] vector;
  } fsirq_ack_type;
endpackage
`default_nettype wire

// file: logic/fsirq_ctrl.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fsirq_ctrl
  import fsirq_pkg::*;
#(
  parameter bit EXT_BOTH_EDGES = 1'b0 // 0: falling only, 1: either edge
)(
  input wire logic clk_sys_i, // 40 MHz system clock
  input wire logic rstn_i, // synchronous, active low
  input wire logic ce_i, // freezes all state when low
  input wire fsirq_pkg::fsirq_bus_type bus_i, // register port request
  output logic [7:0] rdata_o, // read data, cycle after read
  input wire logic ext_irq_n_i, // external request pin, async
  input wire logic [3:0] tmr_ovf_i, // timer overflow pulses
  input wire logic phase2_i, // second machine phase pulse
  input wire logic stack_full_i, // return stack has no room
  input wire logic irq_exit_i, // irq exit instruction executes
  output fsirq_pkg::fsirq_ack_type ack_o, // forced call and vector
  output logic push_pc_o // push program counter only
);
  import fsirq_pkg::*;

  logic [7:0] ctrl_low; // enables and flags, low
  logic [7:0] ctrl_high; // enables and flags, high
  logic ext_s1, ext_s2, ext_s3; // pin synchroniser and history
  logic ph_d; // previous phase level
  logic [7:0] rdata; // registered read data
  fsirq_ack_type ack; // registered acknowledge

  // pin synchroniser: first stage read only by the second
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end
    else if (ce_i)
    begin
      ext_s1 <= ext_irq_n_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // edge detect on synchronised pin
  wire ext_fall = ext_s3 & ~ext_s2;
  wire ext_rise = ~ext_s3 & ext_s2;
  wire ext_edge = ext_fall | (EXT_BOTH_EDGES & ext_rise);

  // register decode
  wire wr_low = bus_i.wr & (bus_i.addr == OFS_CTRL_LOW);
  wire wr_high = bus_i.wr & (bus_i.addr == OFS_CTRL_HIGH);
  wire rd_low = bus_i.rd & (bus_i.addr == OFS_CTRL_LOW);
  wire rd_high = bus_i.rd & (bus_i.addr == OFS_CTRL_HIGH);

  // sample point: rising edge of phase 2
  wire ph_rise = phase2_i & ~ph_d;

  // per-source request flags and enables, priority order
  wire [NSRC-1:0] flags = {ctrl_high[HIGH_T3_FLAG], ctrl_high[HIGH_T2_FLAG],
    ctrl_low[LOW_T1_FLAG], ctrl_low[LOW_T0_FLAG], ctrl_low[LOW_EXT_FLAG]};
  wire [NSRC-1:0] enables = {ctrl_high[HIGH_T3_EN], ctrl_high[HIGH_T2_EN],
    ctrl_low[LOW_T1_EN], ctrl_low[LOW_T0_EN], ctrl_low[LOW_EXT_EN]};
  wire [NSRC-1:0] pend = flags & enables;
  wire gie = ctrl_low[LOW_GIE];

  // acknowledge when gie, room on the stack, an enabled pending flag and phase sample
  wire take = ph_rise & gie & ~stack_full_i & (|pend);

  // fixed priority select, lowest index wins
  wire [NSRC-1:0] grant = pend & (~pend + 5'd1);
  wire [7:0] vector = grant[0] ? VEC_EXT :
    grant[1] ? VEC_T0 :
    grant[2] ? VEC_T1 :
    grant[3] ? VEC_T2 :
    VEC_T3;

  // per-source set (hardware event) and clear (service)
  wire [NSRC-1:0] hw_set = {tmr_ovf_i, ext_edge};
  wire [NSRC-1:0] svc_clr = take ? grant : 5'h00;

  // next flag values: set wins over software or service clear
  logic [NSRC-1:0] sw_val; // software value of flags
  logic [NSRC-1:0] sw_wr; // flag written by software
  logic [NSRC-1:0] next_flags;
  assign sw_val = {bus_i.wdata[HIGH_T3_FLAG], bus_i.wdata[HIGH_T2_FLAG],
    bus_i.wdata[LOW_T1_FLAG], bus_i.wdata[LOW_T0_FLAG],
    bus_i.wdata[LOW_EXT_FLAG]};
  assign sw_wr = {wr_high, wr_high, wr_low, wr_low, wr_low};
  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_flag
      // flag holds until serviced or cleared
      assign next_flags[g] = hw_set[g] |
        (~svc_clr[g] & (sw_wr[g] ? sw_val[g] : flags[g]));
    end
  endgenerate

  // global enable: exit sets, acknowledge clears, else software
  wire next_gie = irq_exit_i ? 1'b1 :
    take ? 1'b0 :
    wr_low ? bus_i.wdata[LOW_GIE] : gie;

  // enables written by software only
  wire [2:0] next_low_en = wr_low ? bus_i.wdata[LOW_T1_EN:LOW_EXT_EN]
    : ctrl_low[LOW_T1_EN:LOW_EXT_EN];
  wire [1:0] next_high_en = wr_high ? bus_i.wdata[HIGH_T3_EN:HIGH_T2_EN]
    : ctrl_high[HIGH_T3_EN:HIGH_T2_EN];

  // assembled next register images with reserved bits zero
  wire [7:0] next_low = LOW_MASK & {1'b0, next_flags[2:0],
    next_low_en, next_gie};
  wire [7:0] next_high = HIGH_MASK & {2'b00, next_flags[4:3], 2'b00,
    next_high_en};

  // read mux
  wire [7:0] next_rdata = rd_low ? ctrl_low :
    rd_high ? ctrl_high : 8'h00;

  // control registers
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ctrl_low <= LOW_RESET;
      ctrl_high <= HIGH_RESET;
    end
    else if (ce_i)
    begin
      ctrl_low <= next_low;
      ctrl_high <= next_high;
    end
  end

  // phase history, read data, acknowledge
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ph_d <= 1'b0;
      rdata <= 8'h00;
      ack <= '0;
    end
    else if (ce_i)
    begin
      ph_d <= phase2_i;
      rdata <= next_rdata;
      ack.call <= take;
      ack.vector <= take ? vector : ack.vector;
    end
  end

  assign rdata_o = rdata;
  assign ack_o = ack;
  assign push_pc_o = ack.call;

  // assertions
  // all of them run on the system clock and sleep during reset;
  // each guards the take, the flags, the global enable, the reserved bits, the read port or the clock enable freeze
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  // an acknowledge is taken on this edge
  sequence s_take;
    ce_i && take;
  endsequence

  // the irq exit instruction executes on this edge
  sequence s_exit;
    ce_i && irq_exit_i;
  endsequence

  // a read strobe is taken on this edge
  sequence s_read;
    ce_i && bus_i.rd;
  endsequence

  // forced call follows every take
  chk_ack_after_take: assert property (
    s_take |=> ack_o.call)
    else $error("acknowledge missing after take");

  // forced call lasts a single cycle
  chk_call_pulse: assert property (
    ce_i && ack_o.call |=> !ack_o.call)
    else $error("forced call longer than one cycle");

  // vector stays put between takes
  chk_vector_held: assert property (
    ce_i && !take |=> $stable(ack_o.vector))
    else $error("vector changed without a take");

  // taking a request drops the global enable
  chk_gie_cleared: assert property (
    s_take ##0 !irq_exit_i |=> !ctrl_low[LOW_GIE])
    else $error("global enable not cleared on acknowledge");

  // nothing is taken while the stack is full
  chk_stack_full: assert property (
    ce_i && stack_full_i |=> !ack_o.call)
    else $error("acknowledge while stack full");

  // irq exit raises the global enable
  chk_exit_sets_gie: assert property (
    s_exit |=> ctrl_low[LOW_GIE])
    else $error("irq exit did not set global enable");

  // external wins whenever it is pending
  chk_ext_vector: assert property (
    s_take ##0 pend[0] |=> ack_o.vector == VEC_EXT)
    else $error("external not given priority");

  // timer 0 wins when external is not pending
  chk_t0_vector: assert property (
    s_take ##0 (pend[1:0] == 2'b10) |=> ack_o.vector == VEC_T0)
    else $error("timer 0 vector wrong");

  // timer 1 wins over timers 2 and 3
  chk_t1_vector: assert property (
    s_take ##0 (pend[2:0] == 3'b100) |=> ack_o.vector == VEC_T1)
    else $error("timer 1 vector wrong");

  // timer 2 wins over timer 3
  chk_t2_vector: assert property (
    s_take ##0 (pend[3:0] == 4'b1000) |=> ack_o.vector == VEC_T2)
    else $error("timer 2 vector wrong");

  // timer 3 alone
  chk_t3_vector: assert property (
    s_take ##0 (pend == 5'b10000) |=> ack_o.vector == VEC_T3)
    else $error("timer 3 vector wrong");

  // synchronised pin edge raises the external flag
  chk_ext_flag_set: assert property (
    ce_i && ext_edge |=> ctrl_low[LOW_EXT_FLAG])
    else $error("external flag not set");

  // timer 0 overflow raises its flag
  chk_timer_sets: assert property (
    ce_i && tmr_ovf_i[0] |=> ctrl_low[LOW_T0_FLAG])
    else $error("timer 0 flag not set");

  // timer 1 overflow raises its flag
  chk_t1_flag_set: assert property (
    ce_i && tmr_ovf_i[1] |=> ctrl_low[LOW_T1_FLAG])
    else $error("timer 1 flag not set");

  // timer 2 overflow raises its flag
  chk_t2_flag_set: assert property (
    ce_i && tmr_ovf_i[2] |=> ctrl_high[HIGH_T2_FLAG])
    else $error("timer 2 flag not set");

  // timer 3 overflow raises its flag
  chk_t3_flag_set: assert property (
    ce_i && tmr_ovf_i[3] |=> ctrl_high[HIGH_T3_FLAG])
    else $error("timer 3 flag not set");

  // serviced external flag drops unless set again
  chk_ext_flag_clear: assert property (
    s_take ##0 pend[0] ##0 !hw_set[0] |=> !ctrl_low[LOW_EXT_FLAG])
    else $error("external flag not cleared on service");

  // serviced timer 0 flag drops unless set again
  chk_t0_flag_clear: assert property (
    s_take ##0 (pend[1:0] == 2'b10) ##0 !hw_set[1]
    |=> !ctrl_low[LOW_T0_FLAG])
    else $error("timer 0 flag not cleared on service");

  // serviced timer 3 flag drops unless set again
  chk_t3_flag_clear: assert property (
    s_take ##0 (pend == 5'b10000) ##0 !hw_set[4]
    |=> !ctrl_high[HIGH_T3_FLAG])
    else $error("timer 3 flag not cleared on service");

  // a pending flag survives idle cycles
  chk_flag_holds: assert property (
    ce_i && ctrl_high[HIGH_T2_FLAG] && !wr_high && !svc_clr[3]
    |=> ctrl_high[HIGH_T2_FLAG])
    else $error("timer 2 flag dropped");

  // unused bits never show a one
  chk_reserved_zero: assert property (
    (ctrl_low[7] == 1'b0) && (ctrl_high[7:6] == 2'b00)
    && (ctrl_high[3:2] == 2'b00))
    else $error("reserved bit nonzero");

  // takes happen only at the phase sample
  chk_sample_phase: assert property (
    ce_i && !ph_rise |=> !ack_o.call)
    else $error("acknowledge off phase sample");

  // no take with the global enable low
  chk_needs_enable: assert property (
    ce_i && !gie |=> !ack_o.call)
    else $error("acknowledge without global enable");

  // no take without an enabled pending flag
  chk_ack_needs_pend: assert property (
    ce_i && (pend == 5'h00) |=> !ack_o.call)
    else $error("acknowledge without enabled request");

  // low register read returns its image
  chk_read_low: assert property (
    s_read ##0 rd_low |=> rdata_o == $past(ctrl_low))
    else $error("low register read wrong");

  // high register read returns its image
  chk_read_high: assert property (
    s_read ##0 rd_high |=> rdata_o == $past(ctrl_high))
    else $error("high register read wrong");

  // read data is zero without a read strobe
  chk_read_idle: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data without strobe");

  // clock enable low freezes both registers
  chk_frozen_regs: assert property (
    !ce_i |=> $stable(ctrl_low) && $stable(ctrl_high))
    else $error("registers moved while frozen");
endmodule // fsirq_ctrl
`default_nettype wire

// file: verification/fsirq_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// sequencer side: machine phase, return stack and irq exit
module fsirq_seq_model
#(
  parameter int DEPTH = 1 // stack levels, small on purpose
)(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic call_i, // forced call pushes the pc
  input wire logic ret_i, // bench asks for an irq exit
  output logic phase2_o, // high one cycle in four
  output logic full_o, // no room left on the stack
  output logic exit_o // irq exit instruction pulse
);
  logic [1:0] div; // machine phase counter
  int depth; // occupied stack levels
  assign phase2_o = (div == 2'h3);
  assign full_o = (depth >= DEPTH);
  // phase counter, pushes and pops
  always_ff @(posedge clk_sys_i)
  begin
    exit_o <= rstn_i & ret_i;
    if (!rstn_i)
    begin
      div <= 2'h0;
      depth <= 0;
    end
    else
    begin
      div <= div + 2'h1;
      depth <= depth + int'(call_i) - int'(ret_i);
    end
  end
endmodule // fsirq_seq_model
`default_nettype wire

// file: verification/five_source_irq_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module five_source_irq_controller_bench;
  import fsirq_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  fsirq_bus_type bus = '0; // register port request
  logic [7:0] rdata;
  logic ext_n = 1'b1; // external pin, idle high
  logic [3:0] tmr = 4'h0; // timer overflow pulses
  fsirq_ack_type ack;
  logic push, ret, ph2, full, ex;
  logic [7:0] r; // random byte
  int vec_q[$] = '{4, 8, 12, 16, 20}; // expected vectors, priority order
  logic ce = 1'b1; // clock enable
  int calls = 0; // forced calls seen
  int failures = 0;
  int comparisons = 0;
  int seed, lo, hi, n; // register model and scratch
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  fsirq_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce),
    .bus_i(bus), .rdata_o(rdata), .ext_irq_n_i(ext_n), .tmr_ovf_i(tmr),
    .phase2_i(ph2), .stack_full_i(full), .irq_exit_i(ex), .ack_o(ack),
    .push_pc_o(push));
  fsirq_seq_model #(.DEPTH(1)) seq (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .call_i(ack.call), .ret_i(ret), .phase2_o(ph2), .full_o(full),
    .exit_o(ex));
  // count every forced call
  always @(posedge clk_sys_i) if (ack.call === 1'b1) calls++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
  endtask
  // read data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 check(rdata, exp, "read data");
  endtask
  task automatic ret_pulse();
    @(posedge clk_sys_i);
    ret <= 1'b1;
    @(posedge clk_sys_i);
    ret <= 1'b0;
  endtask
  // bounded wait for the forced call, then its vector
  task automatic wait_call(input logic [7:0] v);
    int k;
    k = 0;
    while (ack.call !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys_i);
      #1 k++;
    end
    check(8'(k < 40), 8'h01, "call taken");
    check(ack.vector, v, "vector");
    check(8'(push), 8'h01, "pc push");
  endtask
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (3000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end
  initial
  begin
    seed = 32'h3467fd7a;
    ret = 1'b0;
    r = 8'($random(seed));
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(OFS_CTRL_LOW, 8'h00);
    wr(8'h40, r);
    rd(8'h40, 8'h00);
    wr(OFS_CTRL_HIGH, r);
    rd(OFS_CTRL_HIGH, r & 8'h33);
    @(posedge clk_sys_i);
    ce <= 1'b0;
    wr(OFS_CTRL_HIGH, ~r);
    ce <= 1'b1;
    rd(OFS_CTRL_HIGH, r & 8'h33);
    wr(OFS_CTRL_LOW, 8'h8e);
    wr(OFS_CTRL_HIGH, 8'h03);
    @(posedge clk_sys_i);
    tmr <= 4'hf;
    ext_n <= 1'b0;
    @(posedge clk_sys_i);
    tmr <= 4'h0;
    repeat (12) @(posedge clk_sys_i);
    lo = 8'h7e;
    hi = 8'h33;
    rd(OFS_CTRL_LOW, 8'(lo));
    rd(OFS_CTRL_HIGH, 8'(hi));
    check(8'(calls), 8'h00, "calls");
    lo = lo | 1;
    wr(OFS_CTRL_LOW, 8'(lo));
    // one source per pass, in priority order
    for (int i = 0; i < NSRC; i++)
    begin
      wait_call(8'(vec_q.pop_front()));
      lo = lo & ~1;
      if (i < 3)
        lo = lo & ~(1 << (4 + i));
      else
        hi = hi & ~(1 << (1 + i));
      rd(OFS_CTRL_LOW, 8'(lo));
      rd(OFS_CTRL_HIGH, 8'(hi));
      n = calls;
      wr(OFS_CTRL_LOW, 8'(lo | 1));
      repeat (12) @(posedge clk_sys_i);
      check(8'(calls - n), 8'h00, "held call");
      wr(OFS_CTRL_LOW, 8'(lo));
      ret_pulse();
      lo = lo | 1;
    end
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_CTRL_LOW, 8'h0f);
    rd(OFS_CTRL_HIGH, 8'h03);
    give_verdict();
  end
endmodule // five_source_irq_controller_bench
`default_nettype wire
